// File: common/rap_pkg.sv
package rap_pkg;
	// Command codes on cmd_i
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_ACTIVATE = 2'h1;
	localparam logic [1:0] CMD_READ = 2'h2;
	localparam logic [1:0] CMD_PRECHARGE = 2'h3;

	// Register byte offsets
	localparam logic [11:0] REG_CFG = 12'h000;
	localparam logic [11:0] REG_TIMING = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;

	// Configuration, timing and status fields
	localparam int CFG_AL_LSB = 0;
	localparam int CFG_CL_LSB = 3;
	localparam int CFG_BL8_BIT = 6;
	localparam int TIM_RAS_LSB = 0;
	localparam int TIM_RTP_LSB = 8;
	localparam int TIM_RP_LSB = 16;
	localparam int STAT_OPEN_LSB = 0;
	localparam int STAT_PEND_LSB = 8;
	localparam int STAT_PRE_LSB = 16;

	localparam logic [2:0] AL_RESET = 3'h0;
	localparam logic [2:0] CL_RESET = 3'h3;
	localparam logic BL8_RESET = 1'b0;

	// Timing in picoseconds, cycle counts derived from the clock
	localparam int CLK_PERIOD_PS = 10000;
	localparam int ROW_ACTIVE_MIN_PS = 40000;
	localparam int READ_TO_PRE_PS = 7500;
	localparam int PRE_PERIOD_PS = 15000;
	localparam logic [7:0] ROW_ACTIVE_CYC =
		8'((ROW_ACTIVE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [7:0] READ_TO_PRE_CYC =
		8'((READ_TO_PRE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [7:0] PRE_PERIOD_CYC =
		8'((PRE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// Prefetch floor and half bursts in clocks
	localparam logic [7:0] PREFETCH_GAP = 8'h02;
	localparam logic [7:0] HALF_BL4 = 8'h02;
	localparam logic [7:0] HALF_BL8 = 8'h04;
	localparam int RL_PIPE = 16;

	typedef enum logic [3:0] {
		BANK_IDLE = 4'h1,
		BANK_OPEN = 4'h2,
		BANK_PEND = 4'h4,
		BANK_PRE = 4'h8
	} rap_bank_state_type;
endpackage

// File: verilog/rap_bank_timer.sv
`timescale 1ns/100ps
`default_nettype none
module rap_bank_timer (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic act_i,
	input wire logic rd_i,
	input wire logic ap_i,
	input wire logic pre_i,
	input wire logic [2:0] added_latency_i,
	input wire logic bl8_i,
	input wire logic [7:0] ras_cyc_i,
	input wire logic [7:0] rtp_cyc_i,
	input wire logic [7:0] rp_cyc_i,
	output logic start_o,
	output logic open_o,
	output logic pend_o,
	output logic prech_o
);
	rap_pkg::rap_bank_state_type state, next_state;
	logic [7:0] ras_cnt, next_ras_cnt;
	logic [7:0] sched_cnt, next_sched_cnt;
	logic [7:0] rtp_cnt, next_rtp_cnt;
	logic [7:0] rp_cnt, next_rp_cnt;
	logic next_start;

	function automatic logic [7:0] dec(input logic [7:0] v);
		return (v == 8'h00) ? 8'h00 : v - 8'h01;
	endfunction

	always_comb begin
		next_state = state;
		next_ras_cnt = dec(ras_cnt);
		next_sched_cnt = dec(sched_cnt);
		next_rtp_cnt = dec(rtp_cnt);
		next_rp_cnt = dec(rp_cnt);
		next_start = 1'b0;
		case (state)
			rap_pkg::BANK_IDLE: begin
				if (act_i) begin
					next_state = rap_pkg::BANK_OPEN;
					next_ras_cnt = dec(ras_cyc_i);
				end
			end
			rap_pkg::BANK_OPEN: begin
				if (rd_i && ap_i) begin
					next_state = rap_pkg::BANK_PEND;
					next_sched_cnt = dec(8'(added_latency_i) + (bl8_i ? rap_pkg::HALF_BL8
						: rap_pkg::HALF_BL4));
					next_rtp_cnt = dec(8'(added_latency_i) + (bl8_i ? rap_pkg::PREFETCH_GAP
						: 8'h00) + ((rtp_cyc_i > rap_pkg::PREFETCH_GAP) ? rtp_cyc_i
						: rap_pkg::PREFETCH_GAP));
				end else if (pre_i) begin
					next_state = rap_pkg::BANK_PRE;
					next_rp_cnt = dec(rp_cyc_i);
				end
			end
			rap_pkg::BANK_PEND: begin
				if (sched_cnt == 8'h00 && ras_cnt == 8'h00 && rtp_cnt == 8'h00) begin
					next_state = rap_pkg::BANK_PRE;
					next_start = 1'b1;
					next_rp_cnt = dec(rp_cyc_i);
				end
			end
			rap_pkg::BANK_PRE: begin
				if (rp_cnt == 8'h00) begin
					// Activate legal on the edge the precharge period ends
					if (act_i) begin
						next_state = rap_pkg::BANK_OPEN;
						next_ras_cnt = dec(ras_cyc_i);
					end else begin
						next_state = rap_pkg::BANK_IDLE;
					end
				end
			end
			default: begin
				next_state = rap_pkg::BANK_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= rap_pkg::BANK_IDLE;
			ras_cnt <= 8'h00;
			sched_cnt <= 8'h00;
			rtp_cnt <= 8'h00;
			rp_cnt <= 8'h00;
			start_o <= 1'b0;
		end else begin
			state <= next_state;
			ras_cnt <= next_ras_cnt;
			sched_cnt <= next_sched_cnt;
			rtp_cnt <= next_rtp_cnt;
			rp_cnt <= next_rp_cnt;
			start_o <= next_start;
		end
	end

	assign open_o = (state == rap_pkg::BANK_OPEN) || (state == rap_pkg::BANK_PEND);
	assign pend_o = (state == rap_pkg::BANK_PEND);
	assign prech_o = (state == rap_pkg::BANK_PRE);
endmodule
`default_nettype wire

// File: verilog/rap_top.sv
`timescale 1ns/100ps
`default_nettype none
module rap_top #(
	parameter int BANKS = 4,
	parameter int DQ_WIDTH = 16
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_i,
	input wire logic [$clog2(BANKS)-1:0] bank_i,
	input wire logic a10_i,
	input wire logic [DQ_WIDTH-1:0] array_data_i,
	output logic [BANKS-1:0] pre_start_o,
	output logic [BANKS-1:0] bank_open_o,
	output logic rd_valid_o,
	output logic [DQ_WIDTH-1:0] dq_o,
	output logic lower_byte_strobe_oe_o,
	output logic upper_byte_strobe_oe_o
);
	generate
		if (BANKS < 2 || BANKS > 8 || (DQ_WIDTH != 8 && DQ_WIDTH != 16)) begin : g_bad
			$error("rap_top: unsupported BANKS or DQ_WIDTH");
		end
	endgenerate

	localparam int RL_W = rap_pkg::RL_PIPE;
	localparam int BANK_W = $clog2(BANKS);

	logic [2:0] added_latency, next_added_latency;
	logic [2:0] cas_latency, next_cas_latency;
	logic bl8, next_bl8;
	logic [7:0] ras_cyc, next_ras_cyc;
	logic [7:0] rtp_cyc, next_rtp_cyc;
	logic [7:0] rp_cyc, next_rp_cyc;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic [BANKS-1:0] start, open, pend, prech;
	logic [RL_W-1:0] rd_pipe, next_rd_pipe;
	logic [2:0] beats_left, next_beats_left;
	logic next_rd_valid;
	logic [DQ_WIDTH-1:0] next_dq;

	function automatic logic [31:0] widen(input logic [BANKS-1:0] v);
		return 32'(v);
	endfunction

	// Register bus: one wait state, registered answer
	always_comb begin
		next_added_latency = added_latency;
		next_cas_latency = cas_latency;
		next_bl8 = bl8;
		next_ras_cyc = ras_cyc;
		next_rtp_cyc = rtp_cyc;
		next_rp_cyc = rp_cyc;
		next_prdata = prdata_o;
		next_pslverr = 1'b0;
		next_pready = psel_i && penable_i && !pready_o;
		if (next_pready) begin
			next_prdata = 32'h00000000;
			case (paddr_i)
				rap_pkg::REG_CFG: begin
					next_prdata = {25'h0000000, bl8, cas_latency, added_latency};
				end
				rap_pkg::REG_TIMING: begin
					next_prdata = {8'h00, rp_cyc, rtp_cyc, ras_cyc};
				end
				rap_pkg::REG_STATUS: begin
					next_prdata = (widen(open) << rap_pkg::STAT_OPEN_LSB)
						| (widen(pend) << rap_pkg::STAT_PEND_LSB)
						| (widen(prech) << rap_pkg::STAT_PRE_LSB);
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		// Writes land on the completing edge only
		if (psel_i && penable_i && pready_o && pwrite_i) begin
			if (paddr_i == rap_pkg::REG_CFG) begin
				next_added_latency = pwdata_i[rap_pkg::CFG_AL_LSB +: 3];
				next_cas_latency = pwdata_i[rap_pkg::CFG_CL_LSB +: 3];
				next_bl8 = pwdata_i[rap_pkg::CFG_BL8_BIT];
			end else if (paddr_i == rap_pkg::REG_TIMING) begin
				// Row and precharge zero is raised to one; dec loads a zero count for either value
				next_ras_cyc = (pwdata_i[rap_pkg::TIM_RAS_LSB +: 8] == 8'h00) ? 8'h01
					: pwdata_i[rap_pkg::TIM_RAS_LSB +: 8];
				next_rtp_cyc = pwdata_i[rap_pkg::TIM_RTP_LSB +: 8];
				next_rp_cyc = (pwdata_i[rap_pkg::TIM_RP_LSB +: 8] == 8'h00) ? 8'h01
					: pwdata_i[rap_pkg::TIM_RP_LSB +: 8];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			added_latency <= rap_pkg::AL_RESET;
			cas_latency <= rap_pkg::CL_RESET;
			bl8 <= rap_pkg::BL8_RESET;
			ras_cyc <= rap_pkg::ROW_ACTIVE_CYC;
			rtp_cyc <= rap_pkg::READ_TO_PRE_CYC;
			rp_cyc <= rap_pkg::PRE_PERIOD_CYC;
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			added_latency <= next_added_latency;
			cas_latency <= next_cas_latency;
			bl8 <= next_bl8;
			ras_cyc <= next_ras_cyc;
			rtp_cyc <= next_rtp_cyc;
			rp_cyc <= next_rp_cyc;
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= pslverr_o ? 1'b0 : next_pslverr;
		end
	end

	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			logic hit;
			assign hit = cmd_valid_i && (bank_i == BANK_W'(b));
			rap_bank_timer u_timer (
				.mclk_i(mclk_i),
				.arst_n_i(arst_n_i),
				.act_i(hit && cmd_i == rap_pkg::CMD_ACTIVATE),
				.rd_i(hit && cmd_i == rap_pkg::CMD_READ),
				.ap_i(a10_i),
				// A10 with precharge closes every bank
				.pre_i(cmd_valid_i && cmd_i == rap_pkg::CMD_PRECHARGE && (hit || a10_i)),
				.added_latency_i(added_latency),
				.bl8_i(bl8),
				.ras_cyc_i(ras_cyc),
				.rtp_cyc_i(rtp_cyc),
				.rp_cyc_i(rp_cyc),
				.start_o(start[b]),
				.open_o(open[b]),
				.pend_o(pend[b]),
				.prech_o(prech[b])
			);
		end
	endgenerate

	// Read data path
	always_comb begin
		logic [3:0] rl;
		logic hit;
		rl = 4'(added_latency) + 4'(cas_latency);
		hit = 1'b0;
		next_rd_pipe = {rd_pipe[RL_W-2:0], cmd_valid_i && cmd_i == rap_pkg::CMD_READ};
		hit = (rl != 4'h0) && rd_pipe[rl - 4'h1];
		next_dq = dq_o;
		if (hit) begin
			next_rd_valid = 1'b1;
			next_beats_left = bl8 ? 3'h3 : 3'h1;
		end else if (beats_left != 3'h0) begin
			next_rd_valid = 1'b1;
			next_beats_left = beats_left - 3'h1;
		end else begin
			next_rd_valid = 1'b0;
			next_beats_left = 3'h0;
		end
		if (next_rd_valid) begin
			next_dq = array_data_i;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_pipe <= '0;
			beats_left <= 3'h0;
			rd_valid_o <= 1'b0;
			dq_o <= '0;
			lower_byte_strobe_oe_o <= 1'b0;
			upper_byte_strobe_oe_o <= 1'b0;
			pre_start_o <= '0;
			bank_open_o <= '0;
		end else begin
			rd_pipe <= next_rd_pipe;
			beats_left <= next_beats_left;
			rd_valid_o <= next_rd_valid;
			dq_o <= next_dq;
			lower_byte_strobe_oe_o <= next_rd_valid;
			upper_byte_strobe_oe_o <= next_rd_valid && (DQ_WIDTH == 16);
			// Registered again so every port leaves a flop
			pre_start_o <= start;
			bank_open_o <= open;
		end
	end
endmodule
`default_nettype wire

// File: tb/rap_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rap_top_monitor #(
	parameter int BANKS = 4,
	parameter int DQ_WIDTH = 16
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [11:0] paddr_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_i,
	input wire logic [$clog2(BANKS)-1:0] bank_i,
	input wire logic a10_i,
	input wire logic [BANKS-1:0] pre_start_o,
	input wire logic [BANKS-1:0] bank_open_o,
	input wire logic rd_valid_o,
	input wire logic lower_byte_strobe_oe_o,
	input wire logic upper_byte_strobe_oe_o
);
	logic rd_ok;
	// Reads to pending banks never occur, so open means accepted
	assign rd_ok = cmd_valid_i && cmd_i == rap_pkg::CMD_READ && bank_open_o[bank_i];
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	property p_lo;
		lower_byte_strobe_oe_o == rd_valid_o;
	endproperty
	a_lo: assert property (p_lo) else $error("lower strobe");
	property p_hi;
		upper_byte_strobe_oe_o == (DQ_WIDTH == 16 ? rd_valid_o : 1'b0);
	endproperty
	a_hi: assert property (p_hi) else $error("upper strobe");
	property p_rdy;
		pready_o |-> psel_i && penable_i && $past(penable_i);
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready cause");
	property p_err;
		pslverr_o |-> pready_o && !(paddr_i inside {12'h000, 12'h004, 12'h008});
	endproperty
	a_err: assert property (p_err) else $error("pslverr cause");
	property p_floor;
		rd_ok && a10_i |=> !pre_start_o[$past(bank_i)] ##1 !pre_start_o[$past(bank_i, 2)];
	endproperty
	a_floor: assert property (p_floor) else $error("precharge early");
	property p_once;
		(pre_start_o & $past(pre_start_o)) == '0;
	endproperty
	a_once: assert property (p_once) else $error("start not a pulse");
	property p_lat;
		rd_ok |-> ##[4:14] rd_valid_o;
	endproperty
	a_lat: assert property (p_lat) else $error("no read data");
	property p_beats;
		$rose(rd_valid_o) |=> rd_valid_o;
	endproperty
	a_beats: assert property (p_beats) else $error("burst short");
endmodule
bind rap_top rap_top_monitor #(.BANKS(BANKS), .DQ_WIDTH(DQ_WIDTH)) u_mon (.*);
`default_nettype wire

// File: tb/rap_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module rap_ctrl_model (
	input wire logic mclk_i,
	output logic cmd_valid_o,
	output logic [1:0] cmd_o,
	output logic [1:0] bank_o,
	output logic a10_o
);
	int cyc = 0, al = 0, extra = 0, rtp_ps = 10000;
	int ready_at[4] = '{0, 0, 0, 0};
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = rap_pkg::CMD_NOP;
		bank_o = 2'h0;
		a10_o = 1'b0;
	end
	always @(posedge mclk_i)
		cyc <= cyc + 1;
	task automatic issue(input logic [1:0] c, input logic [1:0] b, input logic a, output int ce);
		while (c == rap_pkg::CMD_ACTIVATE && cyc + 2 < ready_at[b]) begin
			@(posedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		cmd_valid_o <= 1'b1;
		cmd_o <= c;
		bank_o <= b;
		a10_o <= a;
		@(posedge mclk_i);
		// Released lines show the inverse, not the last value
		cmd_valid_o <= 1'b0;
		cmd_o <= ~c;
		bank_o <= ~b;
		a10_o <= ~a;
		#1;
		ce = cyc;
		if (c == rap_pkg::CMD_READ && a)
			ready_at[b] = ce + al + extra + (rtp_ps + rap_pkg::PRE_PERIOD_PS
				+ rap_pkg::CLK_PERIOD_PS - 1) / rap_pkg::CLK_PERIOD_PS;
	endtask
endmodule
`default_nettype wire

// File: tb/read_auto_precharge_timing_bench.sv
`timescale 1ns/100ps
`default_nettype none
module read_auto_precharge_timing_bench;
	localparam logic [31:0] RST_VAL[4] = '{32'h00000018, 32'h00020104, 32'h0, 32'h0};
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, perr, cmd_valid, a10, rd_valid, lo_oe, hi_oe;
	logic [1:0] cmd, bank;
	logic [15:0] adata = 16'h0000, dq, prev_ad = 16'h0000;
	logic [3:0] pre_start, bank_open;
	int n_errors = 0, num_checks = 0, seed = 32'hb0ad, cyc = 0;
	int al = 0, half = 2, ras = 4, rtp = 1, ce;
	int exp_pre[4] = '{-1, -1, -1, -1};
	int act_at[4] = '{0, 0, 0, 0};
	bit rd_beat[int];
	rap_top dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
		.bank_i(bank), .a10_i(a10), .array_data_i(adata), .pre_start_o(pre_start),
		.bank_open_o(bank_open), .rd_valid_o(rd_valid), .dq_o(dq),
		.lower_byte_strobe_oe_o(lo_oe), .upper_byte_strobe_oe_o(hi_oe));
	rap_ctrl_model ctrl (.mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
		.bank_o(bank), .a10_o(a10));
	always #5 mclk_i = ~mclk_i;
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		adata <= 16'($random(seed));
		prev_ad <= adata;
		#1;
		if (arst_n_i) begin
			for (int b = 0; b < 4; b++)
				check(pre_start[b], cyc == exp_pre[b]);
			check(rd_valid, rd_beat.exists(cyc));
			check({lo_oe, hi_oe}, rd_beat.exists(cyc) ? 2'b11 : 2'b00);
			if (rd_beat.exists(cyc))
				check(dq, prev_ad);
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do @(posedge mclk_i); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cfg(input int a, input int h, input int r, input int t, input int t_ps);
		al = a;
		half = h;
		ras = r;
		rtp = t;
		ctrl.al = a;
		ctrl.extra = h - 2;
		ctrl.rtp_ps = t_ps;
		apb(1'b1, rap_pkg::REG_CFG, 32'(a + 24 + (h == 4 ? 64 : 0)));
		apb(1'b1, rap_pkg::REG_TIMING, 32'(r + t * 256 + 2 * 65536));
	endtask
	task automatic rd(input logic [1:0] b, input logic ap);
		int n;
		ctrl.issue(rap_pkg::CMD_READ, b, ap, ce);
		for (int i = 0; i < half; i++)
			rd_beat[ce + al + int'(rap_pkg::CL_RESET) + i] = 1'b1;
		n = al + half - 2 + (rtp > 2 ? rtp : 2);
		n = n > al + half ? n : al + half;
		n = n > act_at[b] + ras - ce ? n : act_at[b] + ras - ce;
		// Start edge plus one: the pulse leaves an extra flop
		if (ap)
			exp_pre[b] = ce + n + 1;
	endtask
	task automatic reuse(input logic [1:0] b);
		ctrl.issue(rap_pkg::CMD_ACTIVATE, b, 1'b0, act_at[b]);
		repeat (8) @(posedge mclk_i);
		rd(b, 1'b1);
		ctrl.issue(rap_pkg::CMD_ACTIVATE, b, 1'b0, act_at[b]);
		rd(b, 1'b0);
		repeat (12) @(posedge mclk_i);
		check(bank_open[b], 1'b1);
		ctrl.issue(rap_pkg::CMD_PRECHARGE, b, 1'b0, ce);
		repeat (4) @(posedge mclk_i);
		check(bank_open[b], 1'b0);
	endtask
	initial begin
		#200000;
		n_errors++;
		end_sim;
	end
	initial begin
		repeat (8) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0);
			check(rdat, RST_VAL[i]);
			check(perr, i == 3);
		end
		ctrl.issue(rap_pkg::CMD_ACTIVATE, 2'd0, 1'b0, act_at[0]);
		repeat (10) @(posedge mclk_i);
		rd(2'd0, 1'b1);
		repeat (10) @(posedge mclk_i);
		// Long row time forces the postponed start
		cfg(0, 2, 8, 1, 10000);
		ctrl.issue(rap_pkg::CMD_ACTIVATE, 2'd2, 1'b0, act_at[2]);
		ctrl.issue(rap_pkg::CMD_ACTIVATE, 2'd1, 1'b0, act_at[1]);
		rd(2'd1, 1'b1);
		rd(2'd2, 1'b0);
		repeat (12) @(posedge mclk_i);
		check(bank_open, 4'b0100);
		cfg(0, 2, 4, 2, 20000);
		reuse(2'd0);
		cfg(2, 4, 4, 3, 30000);
		reuse(2'd3);
		end_sim;
	end
endmodule
`default_nettype wire
